// ===== core/cic_pkg.sv
/*
 core interrupt control package: register map, bit positions, reset values.
 assumes a 40 MHz single clock and an AHB-Lite register bus.
*/
package cic_pkg;
   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
   localparam logic [7:0] ADDR_OPTION = 8'h04;
   localparam logic [7:0] ADDR_BUS_STATUS = 8'h08;
   localparam logic [7:0] ADDR_BUS_MASK = 8'h0c;
   // ==========================================================
   // control/status bit positions
   localparam int BIT_GIE = 7;
   localparam int BIT_PGIE = 6;
   localparam int BIT_TOIE = 5;
   localparam int BIT_EXIE = 4;
   localparam int BIT_PCIE = 3;
   localparam int BIT_TOF = 2;
   localparam int BIT_EXF = 1;
   localparam int BIT_PCF = 0;
   localparam int BIT_EDGE = 0;
   localparam int NUM_EVT = 3;
   // ==========================================================
   // reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic RST_EDGE = 1'b1;
   localparam logic [2:0] RST_BUS_MASK = 3'h0;
   // ==========================================================
   // ahb constants
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'b0;
endpackage

// ===== core/cic_edge_detect.sv
/*
 edge detector for the port pins: one pulse per changed bit per clock.
 assumes pins already synchronous to clock.
*/
`timescale 1ns/1ps
module cic_edge_detect
#(
   parameter int WIDTH = 5
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [WIDTH-1:0] pins,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   typedef struct packed
   {
      logic [WIDTH-1:0] last;
      logic primed;
   } cic_ed_state_t;

   cic_ed_state_t st_ff;
   cic_ed_state_t nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.last = pins;
      nxt_st.primed = 1'b1;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // no edges until the first sample after reset
   assign rise = st_ff.primed ? (pins & ~st_ff.last) : '0;
   assign fall = st_ff.primed ? (~pins & st_ff.last) : '0;
endmodule

// ===== core/cic_core.sv
/*
 core interrupt control and status register with AHB-Lite slave.
 assumes timer overflow is a one-cycle pulse, pins synchronous, one clock.
*/
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
// Contract
// - timer enable bit5, sticky timer flag bit2
// - pin enable bit4, sticky pin flag bit1
// - port-change enable bit3 gates only request
// - port-change flag bit0 on upper nibble change
// - flags set regardless of any enable
// - pin edge chosen by edge-select bit
`timescale 1ns/1ps
module cic_core
#(
   parameter int PERIPH_W = 8
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic timer_overflow,
   input wire logic ext_irq_pin,
   input wire logic [3:0] port_upper_nibble_pins,
   input wire logic [PERIPH_W-1:0] periph_flags,
   input wire logic [PERIPH_W-1:0] periph_enables,
   output logic irq_request,
   output logic irq
);
   import cic_pkg::*;

   // ==========================================================
   // source numbering: bit of evt, bus status and bus mask
   localparam int SRC_CHG = 0;
   localparam int SRC_PIN = 1;
   localparam int SRC_TMR = 2;
   // sampled pins: upper nibble on top, external pin at bit 0
   localparam int PIN_W = 5;

   typedef struct packed
   {
      logic [7:0] ctrl;
      logic edge_sel;
      logic [2:0] bus_status;
      logic [2:0] bus_mask;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic req;
   } cic_state_t;

   cic_state_t st_ff;
   cic_state_t nxt_st;
   logic [PIN_W-1:0] pin_rise;
   logic [PIN_W-1:0] pin_fall;
   logic [NUM_EVT-1:0] evt;
   logic [NUM_EVT-1:0] src_hit;
   logic core_hit;
   logic periph_hit;
   logic rd_go;
   logic wr_go;

   // ==========================================================
   // change and edge detection
   cic_edge_detect #(.WIDTH(PIN_W)) u_edge
   (
      .clock(clock),
      .rst(rst),
      .pins({port_upper_nibble_pins, ext_irq_pin}),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // ==========================================================
   // register decode, shared by the read and write paths
   typedef enum {REG_CTRL, REG_OPTION, REG_STATUS, REG_MASK, REG_NONE} cic_reg_t;

   function automatic cic_reg_t reg_decode(input logic [7:0] a);
      cic_reg_t r;
      r = REG_NONE;
      case (a)
         ADDR_CTRL_STATUS:
         begin
            r = REG_CTRL;
         end
         ADDR_OPTION:
         begin
            r = REG_OPTION;
         end
         ADDR_BUS_STATUS:
         begin
            r = REG_STATUS;
         end
         ADDR_BUS_MASK:
         begin
            r = REG_MASK;
         end
         default:
         begin
            r = REG_NONE;
         end
      endcase
      return r;
   endfunction

   // ==========================================================
   // flag and enable position of each core source
   function automatic int flag_pos(input int src);
      int p;
      p = BIT_PCF;
      case (src)
         SRC_CHG:
         begin
            p = BIT_PCF;
         end
         SRC_PIN:
         begin
            p = BIT_EXF;
         end
         default:
         begin
            p = BIT_TOF;
         end
      endcase
      return p;
   endfunction

   function automatic int enable_pos(input int src);
      int p;
      p = BIT_PCIE;
      case (src)
         SRC_CHG:
         begin
            p = BIT_PCIE;
         end
         SRC_PIN:
         begin
            p = BIT_EXIE;
         end
         default:
         begin
            p = BIT_TOIE;
         end
      endcase
      return p;
   endfunction

   // ==========================================================
   // read data, captured in the address phase
   function automatic logic [31:0] read_mux(input logic [7:0] a, input cic_state_t s);
      logic [31:0] r;
      r = 32'h0;
      case (reg_decode(a))
         REG_CTRL:
         begin
            r[7:0] = s.ctrl;
         end
         REG_OPTION:
         begin
            r[BIT_EDGE] = s.edge_sel;
         end
         REG_STATUS:
         begin
            r[NUM_EVT-1:0] = s.bus_status;
         end
         REG_MASK:
         begin
            r[NUM_EVT-1:0] = s.bus_mask;
         end
         default:
         begin
            r = 32'h0;
         end
      endcase
      return r;
   endfunction

   // ==========================================================
   // bus qualifiers
   assign rd_go = hsel && hready && htrans[1] && !hwrite;
   assign wr_go = hsel && hready && htrans[1] && hwrite;

   // ==========================================================
   // events, one cycle wide each
   always_comb
   begin
      evt[SRC_CHG] = (pin_rise[PIN_W-1:1] | pin_fall[PIN_W-1:1]) != '0;
      evt[SRC_PIN] = st_ff.edge_sel ? pin_rise[0] : pin_fall[0];
      evt[SRC_TMR] = timer_overflow;
   end

   // ==========================================================
   // request terms: each core flag gated by its own enable
   for (genvar g = 0; g < NUM_EVT; g++)
   begin : g_src
      assign src_hit[g] = st_ff.ctrl[flag_pos(g)] && st_ff.ctrl[enable_pos(g)];
   end

   assign core_hit = src_hit != '0;
   assign periph_hit = st_ff.ctrl[BIT_PGIE] && ((periph_flags & periph_enables) != '0);

   // ==========================================================
   // next state
   always_comb
   begin
      nxt_st = st_ff;
      // write data lands one cycle after its address phase
      nxt_st.wr_pend = wr_go;
      if (wr_go)
      begin
         nxt_st.wr_addr = haddr;
      end
      if (st_ff.wr_pend)
      begin
         case (reg_decode(st_ff.wr_addr))
            REG_CTRL:
            begin
               nxt_st.ctrl = hwdata[7:0];
            end
            REG_OPTION:
            begin
               nxt_st.edge_sel = hwdata[BIT_EDGE];
            end
            REG_STATUS:
            begin
               nxt_st.bus_status = st_ff.bus_status & ~hwdata[NUM_EVT-1:0];
            end
            REG_MASK:
            begin
               nxt_st.bus_mask = hwdata[NUM_EVT-1:0];
            end
            default:
            begin
               nxt_st.bus_mask = st_ff.bus_mask;
            end
         endcase
      end
      // hardware set wins over a same-cycle clear, enables ignored
      for (int i = 0; i < NUM_EVT; i++)
      begin
         if (evt[i])
         begin
            nxt_st.ctrl[flag_pos(i)] = 1'b1;
         end
      end
      nxt_st.bus_status = nxt_st.bus_status | evt;
      if (rd_go)
      begin
         nxt_st.rdata = read_mux(haddr, st_ff);
      end
      nxt_st.req = st_ff.ctrl[BIT_GIE] && (core_hit || periph_hit);
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_ff <= '0;
         st_ff.ctrl <= RST_CTRL;
         st_ff.edge_sel <= RST_EDGE;
         st_ff.bus_mask <= RST_BUS_MASK;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign hrdata = st_ff.rdata;
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign irq_request = st_ff.req;
   assign irq = (st_ff.bus_status & st_ff.bus_mask) != 3'h0;
endmodule

// ===== testbench/cic_sva.sv
/* checker for cic_core: request timing against shadowed enables.
   assumes a zero wait slave and one clock. */
`timescale 1ns/1ps
module cic_sva
#(
   parameter int PERIPH_W = 8
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic timer_overflow,
   input wire logic ext_irq_pin,
   input wire logic [3:0] port_upper_nibble_pins,
   input wire logic [PERIPH_W-1:0] periph_flags,
   input wire logic [PERIPH_W-1:0] periph_enables,
   input wire logic irq_request
);
   // ==========
   // shadow: en[5] edge select, en[4:0] enables
   logic ap;
   logic [7:0] aa;
   logic [5:0] en;
   always_ff @(posedge clock)
   begin
      ap <= !rst && hsel && hready && htrans[1] && hwrite;
      aa <= haddr;
      if (rst)
         en <= 6'h20;
      else if (ap && aa == 8'h00)
         en[4:0] <= hwdata[7:3];
      else if (ap && aa == 8'h04)
         en[5] <= hwdata[0];
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ==========
   // assertions
   a_timer_req: assert property (en[4] && en[2] && timer_overflow |=> ##1 irq_request)
      else $error("no timer request");
   a_pin_rise: assert property (en[5:4] == 2'h3 && en[1] && $rose(ext_irq_pin) |=> ##1 irq_request)
      else $error("no rising pin request");
   a_pin_fall: assert property (en[5:4] == 2'h1 && en[1] && $fell(ext_irq_pin) |=> ##1 irq_request)
      else $error("no falling pin request");
   a_change_req: assert property (en[4] && en[0] && $changed(port_upper_nibble_pins) |=> ##1 irq_request)
      else $error("no change request");
   a_change_gate: assert property (en[4:0] == 5'h10 |=> !irq_request)
      else $error("request while sources disabled");
   a_periph_req: assert property (en[4:3] == 2'h3 && |(periph_flags & periph_enables) |=> irq_request)
      else $error("no peripheral request");
   a_global_off: assert property (!en[4] |=> !irq_request)
      else $error("request with global enable off");
   cover property (irq_request);
   cover property (en[4:0] == 5'h10);
   cover property (!en[5] && $fell(ext_irq_pin));
endmodule
bind cic_core cic_sva #(.PERIPH_W(PERIPH_W)) i_sva (.*);

// ===== testbench/cic_core_tb.sv
/* bench for cic_core: random and corner events, bus reads of flags.
   assumes cic_pkg map and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
   $display("wrong value at %0t: %h not %h", $time, a, b); end end
module cic_core_tb;
   import cic_pkg::*;
   logic clock = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, timer_overflow = 1'h0;
   logic ext_irq_pin = 1'h0, hreadyout, hresp, irq_request, irq;
   logic [7:0] haddr = 8'h0, periph_flags = 8'h0, periph_enables = 8'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [3:0] port_upper_nibble_pins = 4'h0;
   logic [31:0] hwdata = 32'h0, hrdata, q;
   wire hready = hreadyout;
   int n_mismatch = 0, checked = 0;
   always #12.5 clock = !clock;
   cic_core i_dut (.*);
   // ==========
   // tasks
   task automatic complete_run(input int bad);
      n_mismatch += bad;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic edge1;
      int n;
      @(posedge clock);
      for (n = 1; n < 50 && hready !== 1'h1; n++)
         @(posedge clock);
      if (n >= 50)
         complete_run(1);
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= a;
      edge1;
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      edge1;
      q = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0);
      `CHK(q, e)
   endtask
   task automatic ev(input int i);
      if (i == 0) timer_overflow <= 1'h1;
      else if (i == 1) ext_irq_pin <= !ext_irq_pin;
      else port_upper_nibble_pins <= port_upper_nibble_pins ^ 4'($urandom_range(15, 1));
      @(posedge clock);
      timer_overflow <= 1'h0;
      repeat (3) @(posedge clock);
   endtask
   function automatic logic [31:0] cexp(int i);
      return 32'h80 | (32'h20 >> i) | (32'h4 >> i);
   endfunction
   // ==========
   // sequence
   initial
   begin
      void'($urandom(32'h2ef2));
      repeat (20) @(posedge clock);
      rst <= 1'h0;
      rdchk(ADDR_OPTION, 32'h1);
      rdchk(8'h10, 32'h0);
      `CHK(hresp, HRESP_OKAY)
      for (int i = 0; i < 3; i++)
         ev(i);
      rdchk(ADDR_CTRL_STATUS, 32'h7);
      xfer(1'h1, ADDR_CTRL_STATUS, 32'h80);
      ev(2);
      `CHK(irq_request, 1'h0)
      rdchk(ADDR_CTRL_STATUS, 32'h81);
      xfer(1'h1, ADDR_OPTION, 32'h0);
      xfer(1'h1, ADDR_CTRL_STATUS, 32'h90);
      ev(1);
      rdchk(ADDR_CTRL_STATUS, 32'h92);
      xfer(1'h1, ADDR_OPTION, 32'h1);
      $display("done flags without enables");
      for (int i = 0; i < 3; i++)
      begin
         xfer(1'h1, ADDR_CTRL_STATUS, 32'h80 | (32'h20 >> i));
         ev(i);
         `CHK(irq_request, 1'h1)
         rdchk(ADDR_CTRL_STATUS, cexp(i));
      end
      xfer(1'h1, ADDR_CTRL_STATUS, 32'hc0);
      repeat (8)
      begin
         periph_flags <= 8'($urandom);
         periph_enables <= 8'($urandom);
         repeat (3) @(posedge clock);
         `CHK(irq_request, |(periph_flags & periph_enables))
      end
      periph_flags <= 8'hff;
      periph_enables <= 8'hff;
      xfer(1'h1, ADDR_CTRL_STATUS, 32'h78);
      ev(0);
      `CHK(irq_request, 1'h0)
      $display("done request paths");
      xfer(1'h1, ADDR_BUS_STATUS, 32'h7);
      xfer(1'h1, ADDR_BUS_MASK, 32'h4);
      ev(0);
      `CHK(irq, 1'h1)
      xfer(1'h1, ADDR_BUS_STATUS, 32'h4);
      xfer(1'h1, ADDR_BUS_MASK, 32'h0);
      ev(0);
      `CHK(irq, 1'h0)
      rdchk(ADDR_BUS_STATUS, 32'h4);
      $display("done interrupt line");
      complete_run(0);
   end
endmodule
